// >>> srk_keys_model.sv
// keypad keys and run/stop sequencing bits facing the inhibit sequencer
// assumes the bench calls set_pin; pins change just after a rising aclk edge
`timescale 1ns/1ps
module srk_keys_model (
  input  wire logic aclk,
  output logic      stop_key,
  output logic      run_key,
  output logic      fwd_rev_key,
  output logic      seq_run_fwd,
  output logic      seq_run_rev,
  output logic      seq_run_cmd,
  output logic      seq_not_stop,
  output logic      drive_tripped,
  output logic      hardware_enable_state,
  output logic      dc_link_ok,
  output logic      energy_pulse
);
  logic [10:0] pins;
  // idle: not-stop high, hardware enabled, link voltage good
  initial pins = 11'h340;
  assign {energy_pulse, dc_link_ok, hardware_enable_state, drive_tripped, seq_not_stop,
          seq_run_cmd, seq_run_rev, seq_run_fwd, fwd_rev_key, run_key, stop_key} = pins;
  // latches are cleared by dropping the run bits and pulsing not-stop low, or by clearing the latch select bit
  task automatic set_pin(input int i, input logic v);
    @(posedge aclk);
    pins[i] <= v;
  endtask
endmodule

// >>> srk_pkg.sv
// types shared by the run-inhibit sequencer
// assumes srk_regs.svh holds the numbers
package srk_pkg;
  typedef enum logic [1:0] {
    SRK_PERMIT  = 2'b01,
    SRK_INHIBIT = 2'b10
  } srk_state_t;
endpackage

// >>> srk_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes aclk at 50 MHz and a 4 ms background tick
`ifndef SRK_REGS_SVH
`define SRK_REGS_SVH
`define SRK_ADDR_CTRL      8'h00
`define SRK_ADDR_COST_RATE 8'h04
`define SRK_ADDR_FILTER    8'h08
`define SRK_ADDR_STATUS    8'h0c
`define SRK_ADDR_EN_LOW    8'h10
`define SRK_ADDR_EN_HIGH   8'h14
`define SRK_ADDR_RUN_COST  8'h18
`define SRK_CTRL_FWD_REV   0
`define SRK_CTRL_DRIVE_EN  1
`define SRK_CTRL_EN_CLEAR  2
`define SRK_CTRL_LATCH     3
`define SRK_CTRL_STOP_PERM 4
`define SRK_CTRL_KEYPAD    5
`define SRK_CTRL_W         6
`define SRK_CTRL_RESET     6'h02
`define SRK_RESP_OKAY      2'h0
`define SRK_RESP_SLVERR    2'h2
`define SRK_CLK_NS         20
`define SRK_TICK_MS        4
`define SRK_DUAL_RUN_MS    60
`define SRK_TICK_CYCLES    ((`SRK_TICK_MS * 1000000) / `SRK_CLK_NS)
`define SRK_DUAL_TICKS     ((`SRK_DUAL_RUN_MS + `SRK_TICK_MS - 1) / `SRK_TICK_MS)
`endif

// >>> srk_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ps
module srk_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  initial begin
    if (WIDTH < 1) $error("srk_sync: WIDTH must be at least 1");
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> srk_tick.sv
// periodic one-cycle tick generator
// assumes PERIOD counted in aclk cycles
`timescale 1ns/1ps
module srk_tick #(
  parameter int PERIOD = 200000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;
  initial begin
    if (PERIOD < 2) $error("srk_tick: PERIOD must be at least 2");
  end
  always_comb begin
    next_tick = (cnt == 32'(PERIOD - 1));
    next_cnt  = next_tick ? 32'h0 : cnt + 32'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// >>> srk_top.sv
// stop-key run-inhibit sequencer with axi4-lite register slave
// assumes pins asynchronous to aclk, load_power on aclk
`include "srk_regs.svh"
`timescale 1ns/1ps
module srk_top
  import srk_pkg::*;
#(
  parameter int TICK_CYCLES = `SRK_TICK_CYCLES,
  parameter int DUAL_TICKS  = `SRK_DUAL_TICKS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        stop_key,
  input  wire logic        run_key,
  input  wire logic        fwd_rev_key,
  input  wire logic        seq_run_fwd,
  input  wire logic        seq_run_rev,
  input  wire logic        seq_run_cmd,
  input  wire logic        seq_not_stop,
  input  wire logic        drive_tripped,
  input  wire logic        hardware_enable_state,
  input  wire logic        dc_link_ok,
  input  wire logic        energy_pulse,
  input  wire logic [15:0] load_power,
  output logic             sequencer_run,
  output logic             trip_reset,
  output logic             reverse_select,
  output logic             undervoltage_state,
  output logic             drive_disabled
);
  initial begin
    if (TICK_CYCLES < 2) $error("srk_top: TICK_CYCLES too small");
    if (DUAL_TICKS < 1 || DUAL_TICKS > 255) $error("srk_top: DUAL_TICKS out of range");
  end

  // ----------------------------------------
  // pin synchronisers and tick
  // ----------------------------------------
  logic [10:0] pin_q;
  logic        tick;
  srk_sync #(.WIDTH(11)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({stop_key, run_key, fwd_rev_key, seq_run_fwd, seq_run_rev, seq_run_cmd,
               seq_not_stop, drive_tripped, hardware_enable_state, dc_link_ok,
               energy_pulse}),
    .q       (pin_q)
  );
  srk_tick #(.PERIOD(TICK_CYCLES)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );
  logic stop_q, run_q, key_q, fwd_q, rev_q, cmd_q, nstop_q, trip_q, hwen_q, dcok_q, epulse_q;
  assign {stop_q, run_q, key_q, fwd_q, rev_q, cmd_q, nstop_q, trip_q, hwen_q, dcok_q,
          epulse_q} = pin_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------
  // axi4-lite slave and registers
  // ----------------------------------------
  logic [7:0]             aw_addr, next_aw_addr;
  logic [31:0]            w_data, next_w_data;
  logic [3:0]             w_strb, next_w_strb;
  logic                   next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]             next_bresp, next_rresp;
  logic [31:0]            next_rdata;
  logic [`SRK_CTRL_W-1:0] ctrl, next_ctrl;
  logic [15:0]            cost_rate, next_cost_rate;
  logic [15:0]            filter_ivl, next_filter_ivl;
  logic [15:0]            en_low, en_high;
  logic [31:0]            run_cost;
  logic [31:0]            status;
  logic                   do_write;

  always_comb begin
    next_aw_addr    = aw_addr;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_awready    = awready;
    next_wready     = wready;
    next_bvalid     = bvalid;
    next_bresp      = bresp;
    next_arready    = arready;
    next_rvalid     = rvalid;
    next_rresp      = rresp;
    next_rdata      = rdata;
    next_ctrl       = ctrl;
    next_cost_rate  = cost_rate;
    next_filter_ivl = filter_ivl;
    do_write        = !awready && !wready && !bvalid;
    if (awvalid && awready) begin
      next_aw_addr = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready) begin
      next_w_data = wdata;
      next_w_strb = wstrb;
      next_wready = 1'b0;
    end
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = `SRK_RESP_OKAY;
      case (aw_addr)
        `SRK_ADDR_CTRL: begin
          next_ctrl = `SRK_CTRL_W'(merge(32'(ctrl), w_data, w_strb));
        end
        `SRK_ADDR_COST_RATE: begin
          next_cost_rate = 16'(merge(32'(cost_rate), w_data, w_strb));
        end
        `SRK_ADDR_FILTER: begin
          next_filter_ivl = 16'(merge(32'(filter_ivl), w_data, w_strb));
        end
        `SRK_ADDR_STATUS, `SRK_ADDR_EN_LOW, `SRK_ADDR_EN_HIGH, `SRK_ADDR_RUN_COST: begin
        end
        default: begin
          next_bresp = `SRK_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = `SRK_RESP_OKAY;
      case (araddr)
        `SRK_ADDR_CTRL:      next_rdata = 32'(ctrl);
        `SRK_ADDR_COST_RATE: next_rdata = 32'(cost_rate);
        `SRK_ADDR_FILTER:    next_rdata = 32'(filter_ivl);
        `SRK_ADDR_STATUS:    next_rdata = status;
        `SRK_ADDR_EN_LOW:    next_rdata = 32'(en_low);
        `SRK_ADDR_EN_HIGH:   next_rdata = 32'(en_high);
        `SRK_ADDR_RUN_COST:  next_rdata = run_cost;
        default: begin
          next_rdata = 32'h0;
          next_rresp = `SRK_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr    <= 8'h00;
      w_data     <= 32'h0;
      w_strb     <= 4'h0;
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `SRK_RESP_OKAY;
      arready    <= 1'b1;
      rvalid     <= 1'b0;
      rresp      <= `SRK_RESP_OKAY;
      rdata      <= 32'h0;
      ctrl       <= `SRK_CTRL_RESET;
      cost_rate  <= 16'h0;
      filter_ivl <= 16'h0;
    end else begin
      aw_addr    <= next_aw_addr;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      awready    <= next_awready;
      wready     <= next_wready;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      arready    <= next_arready;
      rvalid     <= next_rvalid;
      rresp      <= next_rresp;
      rdata      <= next_rdata;
      ctrl       <= next_ctrl;
      cost_rate  <= next_cost_rate;
      filter_ivl <= next_filter_ivl;
    end
  end

  // ----------------------------------------
  // run-inhibit sequencer
  // ----------------------------------------
  logic       fwd_rev_key_enable, drive_enable_bit, energy_meter_clear;
  logic       sequencer_latch_select, stop_key_permit, keypad_mode;
  srk_state_t state, next_state;
  logic       stop_prev, key_prev, drive_en_smp, next_drive_en_smp;
  logic       lat_fwd, lat_rev, lat_run, next_lat_fwd, next_lat_rev, next_lat_run;
  logic       latch_hold, next_latch_hold;
  logic [7:0] dual_cnt, next_dual_cnt;
  logic       stop_press, stop_hit, dual_done, drive_ok, release_ok, run_req;
  logic       next_seq_run, next_trip_reset, next_reverse, next_uv;
  logic [15:0] next_en_low, next_en_high;
  logic [31:0] next_run_cost;

  assign fwd_rev_key_enable     = ctrl[`SRK_CTRL_FWD_REV];
  assign drive_enable_bit       = ctrl[`SRK_CTRL_DRIVE_EN];
  assign energy_meter_clear     = ctrl[`SRK_CTRL_EN_CLEAR];
  assign sequencer_latch_select = ctrl[`SRK_CTRL_LATCH];
  assign stop_key_permit        = ctrl[`SRK_CTRL_STOP_PERM];
  assign keypad_mode            = ctrl[`SRK_CTRL_KEYPAD];
  assign status = {26'h0, drive_en_smp, latch_hold, reverse_select, undervoltage_state,
                   sequencer_run, state == SRK_INHIBIT};

  always_comb begin
    stop_press = stop_q && !stop_prev;
    // keypad mode enables the stop key; run held in keypad mode resets only
    stop_hit   = stop_press && (stop_key_permit || keypad_mode || trip_q)
                 && !(keypad_mode && run_q);
    next_dual_cnt = dual_cnt;
    if (!(fwd_q && rev_q)) next_dual_cnt = 8'h0;
    else if (tick && dual_cnt != 8'(DUAL_TICKS)) next_dual_cnt = dual_cnt + 8'h1;
    dual_done = (dual_cnt == 8'(DUAL_TICKS));
    next_drive_en_smp = tick ? drive_enable_bit : drive_en_smp;
    drive_ok = next_drive_en_smp && hwen_q;
    next_lat_fwd = sequencer_latch_select && nstop_q && (lat_fwd || fwd_q);
    next_lat_rev = sequencer_latch_select && nstop_q && (lat_rev || rev_q);
    next_lat_run = sequencer_latch_select && nstop_q && (lat_run || cmd_q);
    release_ok = !drive_ok || undervoltage_state || dual_done;
    if (sequencer_latch_select) begin
      release_ok = release_ok || !(lat_fwd || lat_rev || lat_run) || !nstop_q;
      run_req    = (lat_fwd || lat_rev || lat_run) && nstop_q && !(lat_fwd && lat_rev);
    end else begin
      release_ok = release_ok || !(fwd_q || rev_q || cmd_q);
      run_req    = (fwd_q || rev_q || cmd_q) && !(fwd_q && rev_q);
    end
    case (state)
      SRK_PERMIT:  next_state = stop_hit ? SRK_INHIBIT : SRK_PERMIT;
      SRK_INHIBIT: next_state = (release_ok && !stop_hit) ? SRK_PERMIT : SRK_INHIBIT;
      default:     next_state = SRK_INHIBIT;
    endcase
    // dual-run release in latching mode waits for the latches to clear
    next_latch_hold = latch_hold && (lat_fwd || lat_rev || lat_run);
    if (sequencer_latch_select && state == SRK_INHIBIT && next_state == SRK_PERMIT
        && dual_done) next_latch_hold = 1'b1;
    next_seq_run = next_state == SRK_PERMIT && run_req && drive_ok && !undervoltage_state
                   && !next_latch_hold && !trip_q && !stop_hit
                   && !(stop_press && !sequencer_run);
    next_uv         = !dcok_q;
    next_trip_reset = stop_press && trip_q && dcok_q;
    next_reverse    = reverse_select;
    if (key_q && !key_prev && keypad_mode && fwd_rev_key_enable) begin
      next_reverse = !reverse_select;
    end
    next_en_low  = en_low;
    next_en_high = en_high;
    if (energy_meter_clear) begin
      next_en_low  = 16'h0;
      next_en_high = 16'h0;
    end else if (epulse_q) begin
      next_en_low = en_low + 16'h1;
      if (en_low == 16'hffff) next_en_high = en_high + 16'h1;
    end
    next_run_cost = 32'(load_power) * 32'(cost_rate);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state              <= SRK_PERMIT;
      stop_prev          <= 1'b0;
      key_prev           <= 1'b0;
      drive_en_smp       <= 1'b1;
      lat_fwd            <= 1'b0;
      lat_rev            <= 1'b0;
      lat_run            <= 1'b0;
      latch_hold         <= 1'b0;
      dual_cnt           <= 8'h0;
      sequencer_run      <= 1'b0;
      trip_reset         <= 1'b0;
      reverse_select     <= 1'b0;
      undervoltage_state <= 1'b0;
      drive_disabled     <= 1'b0;
      en_low             <= 16'h0;
      en_high            <= 16'h0;
      run_cost           <= 32'h0;
    end else begin
      state              <= next_state;
      stop_prev          <= stop_q;
      key_prev           <= key_q;
      drive_en_smp       <= next_drive_en_smp;
      lat_fwd            <= next_lat_fwd;
      lat_rev            <= next_lat_rev;
      lat_run            <= next_lat_run;
      latch_hold         <= next_latch_hold;
      dual_cnt           <= next_dual_cnt;
      sequencer_run      <= next_seq_run;
      trip_reset         <= next_trip_reset;
      reverse_select     <= next_reverse;
      undervoltage_state <= next_uv;
      drive_disabled     <= !next_drive_en_smp || !hwen_q;
      en_low             <= next_en_low;
      en_high            <= next_en_high;
      run_cost           <= next_run_cost;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_inhibited;
    state == SRK_INHIBIT && !stop_hit;
  endsequence
  sequence s_stop_reset_only;
    stop_press && keypad_mode && run_q && state == SRK_PERMIT;
  endsequence

  a_stop_inhibits: assert property (stop_hit |=> state == SRK_INHIBIT && !sequencer_run)
    else $error("stop press did not withdraw run");
  a_plain_release: assert property (s_inhibited ##0 (!sequencer_latch_select && !fwd_q
    && !rev_q && !cmd_q) |=> state == SRK_PERMIT)
    else $error("inhibit held with run bits low");
  a_latch_release: assert property (s_inhibited ##0 (sequencer_latch_select && !nstop_q)
    |=> state == SRK_PERMIT)
    else $error("inhibit held with not-stop low");
  a_dual_release: assert property (s_inhibited ##0 dual_done |=> state == SRK_PERMIT)
    else $error("dual run did not release inhibit");
  a_uv_release: assert property (s_inhibited ##0 undervoltage_state |=> state == SRK_PERMIT)
    else $error("undervoltage did not release inhibit");
  a_off_release: assert property (s_inhibited ##0 !drive_ok |=> state == SRK_PERMIT)
    else $error("disabled drive did not release inhibit");
  a_latch_hold: assert property (latch_hold |-> !sequencer_run)
    else $error("ran before latches cleared");
  a_keypad_reset: assert property (s_stop_reset_only |=> state == SRK_PERMIT)
    else $error("keypad run-held stop inhibited run");
  a_dir_key: assert property ($changed(reverse_select) |-> $past(keypad_mode
    && fwd_rev_key_enable))
    else $error("direction changed without key enable");
  a_enable_gate: assert property (!drive_en_smp |-> !sequencer_run && drive_disabled)
    else $error("ran with drive enable low");
  a_meter_clear: assert property (energy_meter_clear |=> en_low == 16'h0 && en_high == 16'h0)
    else $error("energy meter not held at zero");
  a_cost_track: assert property (##1 run_cost == $past(load_power) * $past(cost_rate))
    else $error("running cost stale");
  a_stop_no_start: assert property (stop_press && !sequencer_run |=> !sequencer_run)
    else $error("stop press started the drive");
  a_uv_auto: assert property (dcok_q |=> !undervoltage_state)
    else $error("undervoltage not cleared");
  a_dual_restart: assert property (!(fwd_q && rev_q) |=> dual_cnt == 8'h0)
    else $error("dual run timer not restarted");
endmodule

// >>> stop_key_run_inhibit_sequencer_tb.sv
// self-checking bench for the stop-key run-inhibit sequencer
// assumes srk_top with short tick counts and srk_keys_model as the keypad side
`timescale 1ns/1ps
`include "srk_regs.svh"
module stop_key_run_inhibit_sequencer_tb;
  typedef struct packed {logic [31:0] m; logic [31:0] e; logic [1:0] r;} srk_note_t;
  localparam int STOP = 0, RUN = 1, FRK = 2, FWD = 3, REV = 4, NST = 6, TRIP = 7;
  localparam int HWEN = 8, DCOK = 9, EPUL = 10;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, stop_key, run_key, fwd_rev_key;
  logic seq_run_fwd, seq_run_rev, seq_run_cmd, seq_not_stop, drive_tripped;
  logic hardware_enable_state, dc_link_ok, energy_pulse, sequencer_run, trip_reset;
  logic reverse_select, undervoltage_state, drive_disabled;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rs;
  logic [1:0]  bresp, rresp;
  logic [15:0] load_power, cr;
  logic [5:0]  kc [3] = '{6'h22, 6'h03, 6'h23};
  srk_note_t   q [$];
  srk_note_t   nt;
  int          n_fail, comparisons, n_trst;
  srk_top #(.TICK_CYCLES(10), .DUAL_TICKS(4)) uut (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .stop_key,
    .run_key, .fwd_rev_key, .seq_run_fwd, .seq_run_rev, .seq_run_cmd, .seq_not_stop,
    .drive_tripped, .hardware_enable_state, .dc_link_ok, .energy_pulse, .load_power,
    .sequencer_run, .trip_reset, .reverse_select, .undervoltage_state, .drive_disabled);
  srk_keys_model km (.aclk, .stop_key, .run_key, .fwd_rev_key, .seq_run_fwd, .seq_run_rev,
    .seq_run_cmd, .seq_not_stop, .drive_tripped, .hardware_enable_state, .dc_link_ok,
    .energy_pulse);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic fail(input string s);
    n_fail++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic results();
    $display("counts: %0d compared, %0d mismatched", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      fail("write never answered");
      results();
    end
    comparisons++;
    if (bresp !== r) fail("write response");
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] r = `SRK_RESP_OKAY);
    int n;
    q.push_back('{m, e & m, r});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      fail("read never answered");
      results();
    end
  endtask
  task automatic st(input logic [31:0] m, e);
    chk(`SRK_ADDR_STATUS, m, e);
  endtask
  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask
  task automatic p(input int i, input logic v);
    km.set_pin(i, v);
    settle();
  endtask
  task automatic press();
    p(STOP, 1'b1);
    p(STOP, 1'b0);
  endtask
  task automatic lv(input logic g, input logic x, input string s);
    comparisons++;
    if (g !== x) fail(s);
  endtask
  // read results are matched against the oldest note
  always @(posedge aclk) begin
    if (trip_reset === 1'b1) n_trst++;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      nt = q.pop_front();
      comparisons++;
      if (((rdata & nt.m) !== nt.e) || (rresp !== nt.r)) fail("read data mismatch");
    end
  end
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, load_power} = '0;
    rs = 32'h06123de1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(`SRK_ADDR_CTRL, 32'hffffffff, 32'h2);
    chk(`SRK_ADDR_COST_RATE, 32'hffffffff, 32'h0);
    chk(8'h1c, 32'hffffffff, 32'h0, `SRK_RESP_SLVERR);
    wr(8'h1c, 32'h0, `SRK_RESP_SLVERR);
    wr(`SRK_ADDR_STATUS, 32'hffffffff, `SRK_RESP_OKAY);
    st(32'h3f, 32'h20);
    rs = xs(rs);
    wr(`SRK_ADDR_FILTER, rs, `SRK_RESP_OKAY);
    chk(`SRK_ADDR_FILTER, 32'hffffffff, {16'h0, rs[15:0]});
    $display("test registers finished");
    wr(`SRK_ADDR_CTRL, 32'h12, `SRK_RESP_OKAY);
    p(FWD, 1'b1);
    st(32'h3, 32'h2);
    p(STOP, 1'b1);
    st(32'h3, 32'h1);
    p(STOP, 1'b0);
    st(32'h3, 32'h1);
    p(FWD, 1'b0);
    st(32'h1, 32'h0);
    p(FWD, 1'b1);
    press();
    km.set_pin(REV, 1'b1);
    repeat (25) @(posedge aclk);
    km.set_pin(REV, 1'b0);
    km.set_pin(REV, 1'b1);
    repeat (25) @(posedge aclk);
    st(32'h1, 32'h1);
    repeat (60) @(posedge aclk);
    st(32'h1, 32'h0);
    p(REV, 1'b0);
    press();
    p(DCOK, 1'b0);
    st(32'h5, 32'h4);
    p(DCOK, 1'b1);
    st(32'h6, 32'h2);
    $display("test stop and release finished");
    press();
    wr(`SRK_ADDR_CTRL, 32'h10, `SRK_RESP_OKAY);
    repeat (25) @(posedge aclk);
    st(32'h23, 32'h0);
    lv(drive_disabled, 1'b1, "drive not disabled by enable bit");
    wr(`SRK_ADDR_CTRL, 32'h12, `SRK_RESP_OKAY);
    repeat (25) @(posedge aclk);
    lv(drive_disabled, 1'b0, "drive still disabled");
    press();
    p(HWEN, 1'b0);
    st(32'h3, 32'h0);
    lv(drive_disabled, 1'b1, "drive not disabled by hardware enable");
    p(HWEN, 1'b1);
    st(32'h3, 32'h2);
    $display("test disable finished");
    p(FWD, 1'b0);
    wr(`SRK_ADDR_CTRL, 32'h1a, `SRK_RESP_OKAY);
    p(FWD, 1'b1);
    p(FWD, 1'b0);
    press();
    st(32'h1, 32'h1);
    p(NST, 1'b0);
    st(32'h1, 32'h0);
    p(NST, 1'b1);
    p(FWD, 1'b1);
    press();
    km.set_pin(REV, 1'b1);
    repeat (60) @(posedge aclk);
    st(32'h13, 32'h10);
    km.set_pin(FWD, 1'b0);
    p(REV, 1'b0);
    st(32'h13, 32'h10);
    p(NST, 1'b0);
    p(NST, 1'b1);
    $display("test latching finished");
    wr(`SRK_ADDR_CTRL, 32'h22, `SRK_RESP_OKAY);
    p(FWD, 1'b1);
    p(RUN, 1'b1);
    press();
    st(32'h3, 32'h2);
    wr(`SRK_ADDR_CTRL, 32'h12, `SRK_RESP_OKAY);
    press();
    st(32'h1, 32'h1);
    p(RUN, 1'b0);
    p(FWD, 1'b0);
    p(FWD, 1'b1);
    wr(`SRK_ADDR_CTRL, 32'h02, `SRK_RESP_OKAY);
    press();
    st(32'h3, 32'h2);
    p(TRIP, 1'b1);
    press();
    st(32'h3, 32'h1);
    lv(n_trst == 1, 1'b1, "trip reset pulse missing");
    p(DCOK, 1'b0);
    press();
    lv(n_trst == 1, 1'b1, "trip reset with link voltage low");
    p(DCOK, 1'b1);
    p(TRIP, 1'b0);
    p(FWD, 1'b0);
    st(32'h1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`SRK_ADDR_CTRL, {26'h0, kc[i]}, `SRK_RESP_OKAY);
      p(FRK, 1'b1);
      p(FRK, 1'b0);
      st(32'h8, (i == 2) ? 32'h8 : 32'h0);
    end
    $display("test keys finished");
    wr(`SRK_ADDR_CTRL, 32'h2, `SRK_RESP_OKAY);
    km.set_pin(EPUL, 1'b1);
    repeat (4) @(posedge aclk);
    p(EPUL, 1'b0);
    chk(`SRK_ADDR_EN_LOW, 32'hffffffff, 32'h5);
    wr(`SRK_ADDR_CTRL, 32'h6, `SRK_RESP_OKAY);
    p(EPUL, 1'b1);
    p(EPUL, 1'b0);
    chk(`SRK_ADDR_EN_LOW, 32'hffffffff, 32'h0);
    chk(`SRK_ADDR_EN_HIGH, 32'hffffffff, 32'h0);
    rs = xs(rs);
    load_power <= rs[15:0];
    cr = rs[31:16];
    wr(`SRK_ADDR_COST_RATE, {16'h0, cr}, `SRK_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(`SRK_ADDR_RUN_COST, 32'hffffffff, 32'(load_power) * 32'(cr));
    $display("test energy finished");
    repeat (2) @(posedge aclk);
    results();
  end
endmodule
